// ### rtl/twm_pkg.sv
// Package for the two-wire master receiver: offsets, fields, codes, types.
// Assumes a classic Wishbone master on clk_i and a link clock for the bus.
//
// Overview of operation
// R1 - Flag, start and enable written together launch START once bus free.
// R2 - Software keeps interface enable set in every control write.
// R3 - After START goes out the flag sets with status code 0x08.
// R4 - Address direction bit selects transmitter or receiver master mode.
// R5 - Software masks prescaler bits of status before decoding the code.
// R6 - Software loads read address into data, then clears flag, start 0.
// R7 - After read address and acknowledge, flag sets with 0x38, 0x40, 0x48.
// R8 - Received byte is readable from data whenever the flag is set after it.
// R9 - Software clears acknowledge enable before the last byte to get NACK.
// R10 - Flag, stop and enable written together drive STOP on the bus.
// R11 - Hardware clears the stop request by itself once STOP is sent.
// R12 - Start while holding the bus gives repeated START, status 0x10.
// R13 - In 0x10 a read address is sent; a write address enters transmit.
// R14 - In 0x38 start 0 releases the bus; start 1 waits for a free bus.
// R15 - In 0x40 clearing flag receives a byte, answering per ack enable.
// R16 - In 0x48 start, stop, or both give repeated START, STOP, STOP+START.
// R17 - In 0x50 clearing flag receives the next byte, answered per enable.
// R18 - In 0x58 start/stop bits choose repeated START, STOP or STOP+START.
// R19 - While the flag is set the serial clock is held low; here it is released after reset and in 0x38.
package twm_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA   = 4'h8;
  localparam int BIT_FLAG  = 7;
  localparam int BIT_ACKEN = 6;
  localparam int BIT_STA   = 5;
  localparam int BIT_STO   = 4;
  localparam int BIT_WCOL  = 3;
  localparam int BIT_EN    = 2;
  localparam int BIT_IE    = 0;
  localparam logic [7:0] RST_DATA = 8'hFF;

  // ****************************************************************
  // Status codes (prescaler bits zero)
  // ****************************************************************
  localparam logic [7:0] ST_START   = 8'h08;
  localparam logic [7:0] ST_RSTART  = 8'h10;
  localparam logic [7:0] ST_WA_ACK  = 8'h18;
  localparam logic [7:0] ST_WA_NACK = 8'h20;
  localparam logic [7:0] ST_LOST    = 8'h38;
  localparam logic [7:0] ST_RA_ACK  = 8'h40;
  localparam logic [7:0] ST_RA_NACK = 8'h48;
  localparam logic [7:0] ST_RX_ACK  = 8'h50;
  localparam logic [7:0] ST_RX_NACK = 8'h58;
  localparam logic [7:0] ST_IDLE    = 8'hF8;

  typedef enum logic [2:0] {
    CMD_START, CMD_ADDR, CMD_RECV, CMD_STOP, CMD_STOP_START, CMD_RELEASE
  } twm_kind_e;

  typedef struct packed {
    twm_kind_e  kind;
    logic       ack_en;
    logic [7:0] data;
  } twm_cmd_s;

  typedef struct packed {
    logic       set_flag;
    logic [7:0] code;
    logic [7:0] rx;
  } twm_resp_s;

endpackage

// ### rtl/twm_master_rx.sv
// Two-wire master receiver with Wishbone register access.
// Assumes open-drain SCL/SDA resolved outside; link_clk_i runs freely.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module twm_master_rx
  import twm_pkg::*;
(
  input  wire logic       clk_i,      // System clock, 250 MHz
  input  wire logic       rst_i,      // Synchronous reset, active high
  input  wire logic       cyc_i,      // Wishbone cycle
  input  wire logic       stb_i,      // Wishbone strobe
  input  wire logic       we_i,       // Wishbone write enable
  input  wire logic [3:0] adr_i,      // Byte address
  input  wire logic [3:0] sel_i,      // Byte lane selects
  input  wire logic [31:0] dat_i,     // Write data
  output logic      [31:0] dat_o,     // Read data
  output logic            ack_o,      // Wishbone acknowledge
  input  wire logic       link_clk_i, // Bit engine clock
  input  wire logic       scl_i,      // Serial clock line level
  output logic            scl_o,      // Serial clock drive value
  output logic            scl_oe_o,   // Serial clock pull low
  input  wire logic       sda_i,      // Serial data line level
  output logic            sda_o,      // Serial data drive value
  output logic            sda_oe_o    // Serial data pull low
);

  // ****************************************************************
  // System side registers
  // ****************************************************************
  logic       flag_reg, acken_reg, sta_reg, sto_reg, wcol_reg;
  logic       en_reg, ie_reg, busy_reg, req_tgl_reg, ack_reg;
  logic       done_tgl_reg;
  logic [1:0] presc_reg;
  logic [7:0] code_reg, data_reg;
  logic [31:0] dat_reg;
  twm_cmd_s   cmd_reg;
  logic [2:0] done_sync_reg;
  twm_resp_s  resp_sys;

  // Command choice from present status and request bits
  function automatic logic [3:0] pick_cmd(input logic [7:0] code,
                                          input logic start_column, input logic stop_column);
    logic [3:0] r;
    r = {1'b0, CMD_RELEASE};
    if (stop_column && start_column && (code == ST_RA_NACK || code == ST_RX_NACK)) begin
      r = {1'b1, CMD_STOP_START};               // [R16] [R18]
    end else if (stop_column) begin
      r = {1'b1, CMD_STOP};                     // [R10]
    end else if (start_column) begin
      r = {1'b1, CMD_START};                    // [R1] [R12] [R14]
    end else if (code == ST_START || code == ST_RSTART) begin
      r = {1'b1, CMD_ADDR};                     // [R6] [R13]
    end else if (code == ST_RA_ACK || code == ST_RX_ACK) begin
      r = {1'b1, CMD_RECV};                     // [R15] [R17]
    end else if (code == ST_LOST) begin
      r = {1'b1, CMD_RELEASE};                  // [R14]
    end
    return r;
  endfunction

  logic       bus_req, wr_ctrl, launch, resp_fire;
  logic [3:0] pick;
  assign bus_req   = cyc_i && stb_i && !ack_reg;
  assign wr_ctrl   = bus_req && we_i && sel_i[0] && adr_i == ADDR_CTRL;
  assign pick      = pick_cmd(code_reg, dat_i[BIT_STA], dat_i[BIT_STO]);
  // Enable must be written set each time; flag written as one clears it
  // A free bus (idle code, flag clear after STOP) also takes a START
  assign launch    = wr_ctrl && dat_i[BIT_FLAG] && dat_i[BIT_EN] &&
                     (flag_reg || (code_reg == ST_IDLE && dat_i[BIT_STA] &&
                     !dat_i[BIT_STO])) && !busy_reg && pick[3]; // [R1] [R2]
  assign resp_fire = done_sync_reg[2] ^ done_sync_reg[1];

  // Wishbone acknowledge, one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      unique case (adr_i)
        ADDR_CTRL:   dat_reg <= {24'h00_0000, flag_reg, acken_reg, sta_reg,
                                 sto_reg, wcol_reg, en_reg, 1'b0, ie_reg};
        ADDR_STATUS: dat_reg <= {24'h00_0000, code_reg[7:3], 1'b0,
                                 presc_reg};                 // [R5]
        ADDR_DATA:   dat_reg <= {24'h00_0000, data_reg};     // [R8]
        default:     dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits; hardware set of the flag wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg  <= 1'b1;
      acken_reg <= 1'b0;
      sta_reg   <= 1'b0;
      sto_reg   <= 1'b0;
      en_reg    <= 1'b0;
      ie_reg    <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        acken_reg <= dat_i[BIT_ACKEN];
        sta_reg   <= dat_i[BIT_STA];
        sto_reg   <= dat_i[BIT_STO];
        en_reg    <= dat_i[BIT_EN];
        ie_reg    <= dat_i[BIT_IE];
        if (launch) begin
          flag_reg <= 1'b0;
        end
      end
      if (resp_fire) begin
        if (cmd_reg.kind == CMD_STOP || cmd_reg.kind == CMD_STOP_START) begin
          sto_reg <= 1'b0;                                  // [R11]
        end
        if (resp_sys.set_flag) begin
          flag_reg <= 1'b1;                                 // [R3] [R7]
        end
      end
    end
  end

  // Status, prescaler and data registers; write collision detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_reg  <= ST_IDLE;
      presc_reg <= 2'b00;
      data_reg  <= RST_DATA;
      wcol_reg  <= 1'b0;
    end else begin
      if (bus_req && we_i && sel_i[0] && adr_i == ADDR_STATUS) begin
        presc_reg <= dat_i[1:0];
      end
      if (bus_req && we_i && sel_i[0] && adr_i == ADDR_DATA) begin
        if (flag_reg) begin
          data_reg <= dat_i[7:0];
        end else begin
          wcol_reg <= 1'b1;
        end
      end else if (wr_ctrl && !dat_i[BIT_WCOL]) begin
        wcol_reg <= 1'b0;
      end
      if (resp_fire) begin
        code_reg <= resp_sys.code;
        if (cmd_reg.kind == CMD_RECV) begin
          data_reg <= resp_sys.rx;                          // [R8]
        end
      end
    end
  end

  // Command handshake; cmd_reg is stable until the answer returns
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg      <= 1'b0;
      req_tgl_reg   <= 1'b0;
      cmd_reg       <= '{CMD_RELEASE, 1'b0, 8'h00};
      done_sync_reg <= 3'b000;
    end else begin
      done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
      if (launch) begin
        cmd_reg     <= '{twm_kind_e'(pick[2:0]), dat_i[BIT_ACKEN], data_reg};
        req_tgl_reg <= !req_tgl_reg;
        busy_reg    <= 1'b1;
      end else if (resp_fire) begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // ****************************************************************
  // Link side bit engine
  // ****************************************************************
  typedef enum logic [2:0] {L_IDLE, L_START, L_BYTE, L_STOP, L_HOLD}
    twm_link_e;

  twm_link_e  st_reg;
  logic [1:0] step_reg, lrst_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic       owned_reg, nack_reg, scl_oe_reg, sda_oe_reg;
  logic [2:0] req_sync_reg;
  logic [1:0] scl_sync_reg, sda_sync_reg;
  twm_cmd_s   lcmd_reg;
  twm_resp_s  resp_reg;
  logic       lrst, scl_s, sda_s, new_cmd, tx;

  assign lrst    = lrst_reg[1];
  assign scl_s   = scl_sync_reg[1];
  assign sda_s   = sda_sync_reg[1];
  assign new_cmd = req_sync_reg[2] ^ req_sync_reg[1];
  assign tx      = lcmd_reg.kind == CMD_ADDR;
  assign resp_sys = resp_reg;  // Stable while the done toggle crosses

  // Reset and pin synchronisers in the link domain
  always_ff @(posedge link_clk_i) begin
    lrst_reg     <= {lrst_reg[0], rst_i};
    scl_sync_reg <= {scl_sync_reg[0], scl_i};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
    if (lrst) begin
      req_sync_reg <= 3'b000;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
    end
  end

  // Bus sequencer: START, address/data byte, STOP, hold
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      st_reg       <= L_IDLE;
      step_reg     <= 2'd0;
      bit_reg      <= 4'd0;
      shift_reg    <= 8'h00;
      owned_reg    <= 1'b0;
      nack_reg     <= 1'b0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
      done_tgl_reg <= 1'b0;
      lcmd_reg     <= '{CMD_RELEASE, 1'b0, 8'h00};
      resp_reg     <= '{1'b0, ST_IDLE, 8'h00};
    end else begin
      unique case (st_reg)
        L_IDLE, L_HOLD: begin
          // Clock stays low in hold until software answers [R19]
          if (new_cmd) begin
            lcmd_reg  <= cmd_reg;
            step_reg  <= 2'd0;
            bit_reg   <= 4'd0;
            shift_reg <= cmd_reg.data;
            unique case (cmd_reg.kind)
              CMD_START:                st_reg <= L_START;
              CMD_ADDR, CMD_RECV:       st_reg <= L_BYTE;
              CMD_STOP, CMD_STOP_START: st_reg <= L_STOP;
              CMD_RELEASE: begin
                scl_oe_reg   <= 1'b0;                       // [R14]
                sda_oe_reg   <= 1'b0;
                owned_reg    <= 1'b0;
                resp_reg     <= '{1'b0, ST_IDLE, 8'h00};
                done_tgl_reg <= !done_tgl_reg;
                st_reg       <= L_IDLE;
              end
            endcase
          end
        end
        L_START: begin
          unique case (step_reg)
            2'd0: begin
              sda_oe_reg <= 1'b0;
              step_reg   <= 2'd1;
            end
            2'd1: begin
              scl_oe_reg <= 1'b0;
              // Wait for a free bus before pulling data low [R1]
              if (scl_s && sda_s && !scl_oe_reg) begin
                step_reg <= 2'd2;
              end
            end
            2'd2: begin
              sda_oe_reg <= 1'b1;
              step_reg   <= 2'd3;
            end
            2'd3: begin
              scl_oe_reg   <= 1'b1;
              owned_reg    <= 1'b1;
              resp_reg     <= '{1'b1, owned_reg ? ST_RSTART : ST_START,
                                8'h00};                     // [R3] [R12]
              done_tgl_reg <= !done_tgl_reg;
              st_reg       <= L_HOLD;
            end
          endcase
        end
        L_BYTE: begin
          unique case (step_reg)
            2'd0: begin
              if (bit_reg < 4'd8) begin
                sda_oe_reg <= tx && !shift_reg[7];
              end else begin
                sda_oe_reg <= !tx && lcmd_reg.ack_en;       // [R9] [R15]
              end
              step_reg <= 2'd1;
            end
            2'd1: begin
              scl_oe_reg <= 1'b0;
              if (scl_s && !scl_oe_reg) begin   // Slave may stretch clock
                step_reg <= 2'd2;
              end
            end
            2'd2: begin
              step_reg <= 2'd3;
              if (bit_reg < 4'd8) begin
                shift_reg <= {shift_reg[6:0], sda_s};
              end else begin
                nack_reg <= sda_s;
              end
              if (tx && bit_reg < 4'd8 && shift_reg[7] && !sda_s) begin
                // Lost arbitration: let go of both lines [R14]
                sda_oe_reg   <= 1'b0;
                owned_reg    <= 1'b0;
                resp_reg     <= '{1'b1, ST_LOST, 8'h00};    // [R7]
                done_tgl_reg <= !done_tgl_reg;
                st_reg       <= L_IDLE;
              end
            end
            2'd3: begin
              scl_oe_reg <= 1'b1;
              step_reg   <= 2'd0;
              if (bit_reg == 4'd8) begin
                // Data stays put here; the next step0 moves it while the
                // clock is low, so it never moves as the clock falls
                if (tx) begin
                  // Direction bit picks receive or transmit codes [R4]
                  if (lcmd_reg.data[0]) begin
                    resp_reg <= '{1'b1, nack_reg ? ST_RA_NACK : ST_RA_ACK,
                                  8'h00};                   // [R7] [R13]
                  end else begin
                    resp_reg <= '{1'b1, nack_reg ? ST_WA_NACK : ST_WA_ACK,
                                  8'h00};                   // [R13]
                  end
                end else begin
                  resp_reg <= '{1'b1, lcmd_reg.ack_en ? ST_RX_ACK
                                : ST_RX_NACK, shift_reg};   // [R17]
                end
                done_tgl_reg <= !done_tgl_reg;
                st_reg       <= L_HOLD;
              end else begin
                bit_reg <= bit_reg + 4'd1;
              end
            end
          endcase
        end
        L_STOP: begin
          unique case (step_reg)
            2'd0: begin
              sda_oe_reg <= 1'b1;
              step_reg   <= 2'd1;
            end
            2'd1: begin
              scl_oe_reg <= 1'b0;
              if (scl_s && !scl_oe_reg) begin
                step_reg <= 2'd2;
              end
            end
            2'd2: begin
              sda_oe_reg <= 1'b0;                           // [R10]
              step_reg   <= 2'd3;
            end
            2'd3: begin
              owned_reg <= 1'b0;
              step_reg  <= 2'd0;
              if (lcmd_reg.kind == CMD_STOP_START) begin
                st_reg <= L_START;                          // [R16] [R18]
              end else begin
                resp_reg     <= '{1'b0, ST_IDLE, 8'h00};
                done_tgl_reg <= !done_tgl_reg;
                st_reg       <= L_IDLE;
              end
            end
          endcase
        end
      endcase
    end
  end

  // Enables are the sequencer flops, so the clock is low before the flag
  assign scl_oe_o = scl_oe_reg;                             // [R19]
  assign sda_oe_o = sda_oe_reg;

  // Pins: open-drain, so the drive value is always a held low
  always_ff @(posedge link_clk_i) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_launch_wait;
    !flag_reg && busy_reg;
  endsequence

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_reg |=> !ack_reg) else $error("ack held too long");
  a_launch_clears_flag: assert property (@(posedge clk_i) // [R1]
    disable iff (rst_i) launch |=> s_launch_wait)
    else $error("launch did not clear flag");
  a_start_code: assert property (@(posedge clk_i) // [R3]
    disable iff (rst_i) resp_fire && cmd_reg.kind == CMD_START
    |=> flag_reg && (code_reg == ST_START || code_reg == ST_RSTART))
    else $error("START code wrong");
  a_addr_code: assert property (@(posedge clk_i) // [R7]
    disable iff (rst_i) resp_fire && cmd_reg.kind == CMD_ADDR &&
    cmd_reg.data[0] |=> flag_reg && (code_reg == ST_LOST ||
    code_reg == ST_RA_ACK || code_reg == ST_RA_NACK))
    else $error("read address code wrong");
  a_rx_data: assert property (@(posedge clk_i) // [R8]
    disable iff (rst_i) resp_fire && cmd_reg.kind == CMD_RECV
    |=> flag_reg && data_reg == $past(resp_sys.rx))
    else $error("received byte not in data");
  a_stop_clears: assert property (@(posedge clk_i) // [R11]
    disable iff (rst_i) resp_fire && cmd_reg.kind == CMD_STOP
    |=> !sto_reg) else $error("stop request not cleared");
  a_hold_scl_low: assert property (@(posedge link_clk_i) // [R19]
    disable iff (lrst) st_reg == L_HOLD |-> scl_oe_reg)
    else $error("clock released while holding");
  a_ack_drive: assert property (@(posedge link_clk_i) // [R15]
    disable iff (lrst) st_reg == L_BYTE && bit_reg == 4'd8 && !tx &&
    step_reg == 2'd1 |-> sda_oe_reg == lcmd_reg.ack_en)
    else $error("ack bit drive wrong");
  a_start_order: assert property (@(posedge link_clk_i) // [R12]
    disable iff (lrst) st_reg == L_START && step_reg == 2'd2
    |=> sda_oe_reg && !scl_oe_reg ##1 scl_oe_reg && owned_reg)
    else $error("START edge order wrong");

endmodule

// ### tb/twm_slave_model.sv
// Behavioural slave transmitter on the two-wire bus.
// Assumes pulled-up lines resolved by the bench; it only pulls SDA low.
`timescale 1ns/1ps
module twm_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A, // Own address
  parameter logic [7:0] FIRST = 8'hA5  // First byte sent, then counts up
) (
  input  wire logic scl_i,     // Clock line level
  input  wire logic sda_i,     // Data line level
  output logic      sda_pull_o // High pulls data low
);
  logic [7:0] sh;
  logic [7:0] tx;
  int         cnt;
  logic       act;
  logic       rd;
  logic       ph;

  initial begin
    sda_pull_o = 1'b0;
    act = 1'b0;
    cnt = 0;
  end
  // START restarts framing; STOP drops out and releases the line
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b1;
    ph = 1'b0;
    cnt = 0;
    sda_pull_o = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b0;
    sda_pull_o = 1'b0;
  end
  // Sample on rising clock; a NACK from the master ends the read
  always @(posedge scl_i) if (act) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (ph && sda_i) act = 1'b0;
    cnt = cnt + 1;
  end
  // Change data only while the clock is low
  always @(negedge scl_i) if (act) begin
    if (cnt == 8 && !ph) begin
      act = (sh[7:1] == ADDR);
      sda_pull_o = act;
      rd = sh[0];
      tx = FIRST;
    end else if (cnt == 8) begin
      sda_pull_o = 1'b0;
    end else if (cnt == 9) begin
      cnt = 0;
      if (ph) tx = tx + 8'h01;
      ph = rd;
      act = rd;
      sda_pull_o = rd & ~tx[7];
    end else if (ph && cnt > 0) begin
      sda_pull_o = ~tx[7-cnt];
    end
  end
endmodule

// ### tb/tb_twm_master_rx.sv
// Self-checking bench for the two-wire master receiver.
// Assumes a slave model on pulled-up lines and a free link clock.
`timescale 1ns/1ps
module tb_twm_master_rx
  import twm_pkg::*;
;
  localparam logic [6:0] SLV   = 7'h2A;
  localparam logic [7:0] FIRST = 8'hA5;
  logic        clk, rst, cyc, stb, we, ack, link_clk;
  logic [3:0]  adr, sel;
  logic [31:0] dat, rdat;
  logic        scl_oe, sda_oe, sda_pull, scl_dv, sda_dv;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | sda_pull);
  int          error_cnt, checks;

  twm_master_rx i_twm_master_rx (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .link_clk_i(link_clk), .scl_i(scl),
    .scl_o(scl_dv), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_dv),
    .sda_oe_o(sda_oe));
  twm_slave_model #(.ADDR(SLV), .FIRST(FIRST)) i_twm_slave_model (
    .scl_i(scl), .sda_i(sda), .sda_pull_o(sda_pull));

  // Clocks: link rate does not divide the system rate, so phase drifts
  always #2 clk = ~clk;
  always #62.5 link_clk = ~link_clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1;
    dat <= {24'h0, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask
  // Poll the flag, then judge the masked code and the stalled clock
  task automatic wait_code(input logic [7:0] code);
    logic [31:0] q;
    int n;
    n = 0;
    do begin rd(ADDR_CTRL, q); n++; end
      while (q[BIT_FLAG] !== 1'b1 && n < 3000);
    rd(ADDR_STATUS, q);
    chk(q[7:0] & 8'hF8, code);
    chk({7'h0, scl}, 8'h00);
  endtask
  task automatic stop_idle;
    logic [31:0] q;
    int n;
    n = 0;
    wr(ADDR_CTRL, 8'h94);
    do begin rd(ADDR_STATUS, q); n++; end
      while (q[7:0] !== ST_IDLE && n < 3000);
    chk(q[7:0], ST_IDLE);
    rd(ADDR_CTRL, q);
    chk({7'h0, q[BIT_STO]}, 8'h00);
    chk({6'h0, scl, sda}, 8'h03);
    chk({6'h0, scl_dv, sda_dv}, 8'h00);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_reset_vals;
    logic [31:0] q;
    rd(ADDR_CTRL, q);   chk(q[7:0], 8'h80);
    rd(ADDR_STATUS, q); chk(q[7:0], ST_IDLE);
    rd(ADDR_DATA, q);   chk(q[7:0], RST_DATA);
    rd(4'hC, q);        chk(q[7:0], 8'h00);
  endtask
  // Two bytes, NACK on the last, repeated START, one more byte, STOP
  task automatic s_read_two;
    logic [31:0] q;
    wr(ADDR_CTRL, 8'hA4);
    wait_code(ST_START);
    wr(ADDR_DATA, {SLV, 1'b1});
    wr(ADDR_CTRL, 8'h84);
    wait_code(ST_RA_ACK);
    wr(ADDR_CTRL, 8'hC4);
    wait_code(ST_RX_ACK);
    rd(ADDR_DATA, q);
    chk(q[7:0], FIRST);
    wr(ADDR_CTRL, 8'h84);
    wait_code(ST_RX_NACK);
    rd(ADDR_DATA, q);
    chk(q[7:0], FIRST + 8'h01);
    wr(ADDR_CTRL, 8'hA4);
    wait_code(ST_RSTART);
    wr(ADDR_DATA, {SLV, 1'b1});
    wr(ADDR_CTRL, 8'h84);
    wait_code(ST_RA_ACK);
    wr(ADDR_CTRL, 8'h84);
    wait_code(ST_RX_NACK);
    rd(ADDR_DATA, q);
    chk(q[7:0], FIRST);
    stop_idle();
  endtask
  // Unknown address, STOP+START, write address, then a late data write
  task automatic s_addr_nack;
    logic [31:0] q;
    wr(ADDR_CTRL, 8'hA4);
    wait_code(ST_START);
    wr(ADDR_DATA, {7'h13, 1'b1});
    wr(ADDR_CTRL, 8'h84);
    wait_code(ST_RA_NACK);
    wr(ADDR_CTRL, 8'hB4);
    wait_code(ST_START);
    wr(ADDR_DATA, {SLV, 1'b0});
    wr(ADDR_CTRL, 8'h84);
    wait_code(ST_WA_ACK);
    stop_idle();
    wr(ADDR_DATA, 8'h55);
    rd(ADDR_CTRL, q);
    chk({4'h0, q[BIT_WCOL], 3'h0}, 8'h08);
  endtask

  task automatic close_out;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Reset also has to reach the link side, so wait for link edges too
  initial begin
    clk = 1'b0; link_clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0;
    we = 1'b0; adr = '0; sel = '0; dat = '0; error_cnt = 0; checks = 0;
    repeat (16) @(posedge clk);
    repeat (4) @(posedge link_clk);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_reset_vals();
    s_read_two();
    s_addr_nack();
    close_out();
  end
  // Watchdog: all traffic needs well under this span
  initial begin
    #300000;
    error_cnt++;
    close_out();
  end
endmodule
